/* hw/catr_pkg.sv */
/*
  Constants and types for the codec analog test register bank.
  Assumes an APB completer with a 10-bit byte address and a 40 MHz clock.
*/
package catr_pkg;

  // ****************************************************************
  // register indexes and byte addresses
  // ****************************************************************
  localparam logic [7:0] INDEX_TEST_TWO = 8'h3A;
  localparam logic [7:0] INDEX_SHORT_CTRL = 8'h3C;
  localparam logic [7:0] INDEX_TEST_STATUS = 8'h3E;
  localparam logic [9:0] ADDR_TEST_TWO = {INDEX_TEST_TWO, 2'h0};
  localparam logic [9:0] ADDR_SHORT_CTRL = {INDEX_SHORT_CTRL, 2'h0};
  localparam logic [9:0] ADDR_TEST_STATUS = {INDEX_TEST_STATUS, 2'h0};

  // ****************************************************************
  // reset values and writable masks
  // ****************************************************************
  localparam logic [15:0] TEST_TWO_RESET = 16'h0000;
  localparam logic [15:0] TEST_TWO_WMASK = 16'h7FFF;
  localparam logic [15:0] SHORT_CTRL_RESET = 16'h0000;
  localparam logic [15:0] SHORT_CTRL_WMASK = 16'h777F;
  localparam logic [7:0] RETUNE_COUNT_RESET = 8'h00;

  // ****************************************************************
  // analog_test_control_two field positions
  // ****************************************************************
  localparam int BIT_ADC_DITHER_DISABLE = 0;
  localparam int BIT_ADC_LOW_BIAS = 1;
  localparam int BIT_ADC_HANDOFF_FLIP = 2;
  localparam int BIT_ADC_SAMPLE_FLIP = 3;
  localparam int BIT_DAC_AMP_CLASS_A = 4;
  localparam int BIT_DAC_RTZ_DISABLE = 5;
  localparam int BIT_DAC_DOUBLE_CURRENT = 6;
  localparam int BIT_DAC_RTZ_LENGTHEN = 7;
  localparam int BIT_DAC_HANDOFF_FLIP = 8;
  localparam int BIT_DAC_SAMPLE_FLIP = 9;
  localparam int BIT_LINE_GROUND_TIE = 10;
  localparam int BIT_OSC_RETUNE_TRIGGER = 11;
  localparam int BIT_DAC_MONO_COPY = 12;
  localparam int BIT_SPARE = 13;
  localparam int BIT_LINE_AMP_SUPPLY = 14;

  // ****************************************************************
  // headphone_short_control field positions
  // ****************************************************************
  localparam int SHORT_COMMON_MODE_LSB = 0;
  localparam int SHORT_SIDE_MODE_LSB = 2;
  localparam int SHORT_CENTER_LEVEL_LSB = 4;
  localparam int SHORT_LEFT_LEVEL_LSB = 8;
  localparam int SHORT_RIGHT_LEVEL_LSB = 12;

  // ****************************************************************
  // status register layout
  // ****************************************************************
  localparam int STATUS_COUNT_LSB = 0;
  localparam int STATUS_HELD_BIT = 8;

  // ****************************************************************
  // data path width
  // ****************************************************************
  localparam int SAMPLE_W = 16;

  // retune edge watcher
  typedef enum logic {
    RETUNE_IDLE,
    RETUNE_HELD
  } catr_retune_type;

endpackage

/* hw/catr_dac_mono.sv */
/*
  DAC sample stage that can copy the left sample into the right slot.
  Assumes samples arrive on sys_clk with a one-cycle valid strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module catr_dac_mono (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // control
  input wire logic mono,
  // samples in
  input wire logic sample_valid,
  input wire logic [catr_pkg::SAMPLE_W-1:0] left_in,
  input wire logic [catr_pkg::SAMPLE_W-1:0] right_in,
  // samples out
  output logic out_valid,
  output logic [catr_pkg::SAMPLE_W-1:0] left_out,
  output logic [catr_pkg::SAMPLE_W-1:0] right_out
);

  typedef struct packed {
    logic valid;
    logic [catr_pkg::SAMPLE_W-1:0] left;
    logic [catr_pkg::SAMPLE_W-1:0] right;
  } catr_mono_type;

  catr_mono_type r;
  catr_mono_type next_r;

  // load a sample pair, left copied to right in mono
  always_comb begin
    next_r = r;
    next_r.valid = sample_valid;
    if (sample_valid) begin
      next_r.left = left_in;
      next_r.right = mono ? left_in : right_in;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign out_valid = r.valid;
  assign left_out = r.left;
  assign right_out = r.right;

endmodule

`default_nettype wire

/* hw/catr_regs.sv */
/*
  Analog test register bank of a stereo codec, reached over APB.
  Holds converter edge, return-to-zero, bias and supply controls, the
  oscillator retune trigger, the mono DAC copy and the headphone short
  detector settings. Assumes one clock, a synchronous reset, and APB
  signals generated on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module catr_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // apb completer
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // dac sample path
  input wire logic dac_sample_valid,
  input wire logic [catr_pkg::SAMPLE_W-1:0] dac_left_in,
  input wire logic [catr_pkg::SAMPLE_W-1:0] dac_right_in,
  output logic dac_out_valid,
  output logic [catr_pkg::SAMPLE_W-1:0] dac_left_out,
  output logic [catr_pkg::SAMPLE_W-1:0] dac_right_out,
  // pll oscillator
  output logic oscillator_retune_pulse,
  // converter clock edges
  output logic dac_sample_edge_flip,
  output logic dac_handoff_edge_flip,
  output logic adc_sample_edge_flip,
  output logic adc_handoff_edge_flip,
  // dac analog controls
  output logic dac_rtz_enable,
  output logic dac_rtz_lengthen,
  output logic dac_amp_class_ab_enable,
  output logic dac_double_current,
  // adc analog controls
  output logic adc_dither_enable,
  output logic adc_low_bias,
  // line output controls
  output logic line_amp_supply_select,
  output logic line_ground_tie,
  output logic analog_spare,
  // headphone short detector controls
  output logic [2:0] short_level_right,
  output logic [2:0] short_level_left,
  output logic [2:0] short_level_center,
  output logic [1:0] short_mode_side,
  output logic [1:0] short_mode_common
);

  // ****************************************************************
  // state
  // ****************************************************************

  typedef struct packed {
    logic [15:0] test_two;
    logic [15:0] short_ctrl;
    catr_pkg::catr_retune_type retune;
    logic retune_pulse;
    logic [7:0] retune_count;
    logic [31:0] rdata;
    logic err;
  } catr_state_type;

  catr_state_type r;
  catr_state_type next_r;

  // ****************************************************************
  // bus decode
  // ****************************************************************

  logic setup_phase;
  logic access_phase;
  logic hit_test_two;
  logic hit_short_ctrl;
  logic hit_status;
  logic hit_any;
  logic do_write;

  // phases of the apb transfer
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;

  // address match, one aligned word per register
  assign hit_test_two = (paddr == catr_pkg::ADDR_TEST_TWO);
  assign hit_short_ctrl = (paddr == catr_pkg::ADDR_SHORT_CTRL);
  assign hit_status = (paddr == catr_pkg::ADDR_TEST_STATUS);
  assign hit_any = hit_test_two | hit_short_ctrl | hit_status;

  // a write lands only in the access phase of a mapped address;
  // an unmapped setup raises err, which also blocks the write
  assign do_write = access_phase & pwrite & ~r.err;

  // ****************************************************************
  // helpers
  // ****************************************************************

  // byte-lane merge; reserved bits forced to zero by the mask
  // only lanes 0 and 1 exist, upper strobes are ignored
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old_value,
    input logic [31:0] wdata,
    input logic [3:0] strb,
    input logic [15:0] wmask
  );
    logic [15:0] merged;
    merged = old_value;
    if (strb[0]) begin
      merged[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      merged[15:8] = wdata[15:8];
    end
    return merged & wmask;
  endfunction

  // status word: retune count and watcher state
  // status is read only; writes to it are dropped without error
  logic [15:0] status_word;

  always_comb begin
    status_word = 16'h0000;
    status_word[catr_pkg::STATUS_COUNT_LSB +: 8] = r.retune_count;
    status_word[catr_pkg::STATUS_HELD_BIT] =
      (r.retune == catr_pkg::RETUNE_HELD);
  end

  // ****************************************************************
  // next state
  // ****************************************************************

  always_comb begin
    next_r = r;
    next_r.retune_pulse = 1'b0;

    // read data and error are prepared in the setup phase
    if (setup_phase) begin
      next_r.err = ~hit_any;
      next_r.rdata = 32'h0000_0000;
      if (hit_test_two) begin
        next_r.rdata[15:0] = r.test_two;
      end else if (hit_short_ctrl) begin
        next_r.rdata[15:0] = r.short_ctrl;
      end else if (hit_status) begin
        next_r.rdata[15:0] = status_word;
      end
    end

    // register writes; status is read only and ignores them
    if (do_write && hit_test_two) begin
      next_r.test_two = lane_merge(r.test_two, pwdata, pstrb,
        catr_pkg::TEST_TWO_WMASK);
    end
    if (do_write && hit_short_ctrl) begin
      next_r.short_ctrl = lane_merge(r.short_ctrl, pwdata, pstrb,
        catr_pkg::SHORT_CTRL_WMASK);
    end

    // retune watcher: arm on high, fire on the later low
    // a level held high only arms; the pulse needs the fall
    case (r.retune)
      catr_pkg::RETUNE_IDLE: begin
        if (r.test_two[catr_pkg::BIT_OSC_RETUNE_TRIGGER]) begin
          next_r.retune = catr_pkg::RETUNE_HELD;
        end
      end
      catr_pkg::RETUNE_HELD: begin
        if (!r.test_two[catr_pkg::BIT_OSC_RETUNE_TRIGGER]) begin
          next_r.retune = catr_pkg::RETUNE_IDLE;
          next_r.retune_pulse = 1'b1;
          next_r.retune_count = 8'(r.retune_count + 8'h01);
        end
      end
      default: begin
        next_r.retune = catr_pkg::RETUNE_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************

  // synchronous reset: fields, watcher and bus state cleared
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r.test_two <= catr_pkg::TEST_TWO_RESET;
      r.short_ctrl <= catr_pkg::SHORT_CTRL_RESET;
      r.retune <= catr_pkg::RETUNE_IDLE;
      r.retune_pulse <= 1'b0;
      r.retune_count <= catr_pkg::RETUNE_COUNT_RESET;
      r.rdata <= 32'h0000_0000;
      r.err <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // bus answers
  // ****************************************************************

  // zero wait states: data was latched during setup, so a status
  // change between setup and access shows on the next read
  assign pready = access_phase;
  assign prdata = r.rdata;
  assign pslverr = access_phase & r.err;

  // ****************************************************************
  // dac data path
  // ****************************************************************

  // registered sample stage; mono comes from the live register
  catr_dac_mono catr_dac_mono_i (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .mono(r.test_two[catr_pkg::BIT_DAC_MONO_COPY]),
    .sample_valid(dac_sample_valid),
    .left_in(dac_left_in),
    .right_in(dac_right_in),
    .out_valid(dac_out_valid),
    .left_out(dac_left_out),
    .right_out(dac_right_out)
  );

  // ****************************************************************
  // analog control outputs
  // ****************************************************************

  // oscillator retune strobe
  assign oscillator_retune_pulse = r.retune_pulse;

  // converter clock edge selects, handed out as levels;
  // no clock is switched inside this block
  assign dac_sample_edge_flip =
    r.test_two[catr_pkg::BIT_DAC_SAMPLE_FLIP];
  assign dac_handoff_edge_flip =
    r.test_two[catr_pkg::BIT_DAC_HANDOFF_FLIP];
  assign adc_sample_edge_flip =
    r.test_two[catr_pkg::BIT_ADC_SAMPLE_FLIP];
  assign adc_handoff_edge_flip =
    r.test_two[catr_pkg::BIT_ADC_HANDOFF_FLIP];

  // dac return-to-zero and amplifier class
  assign dac_rtz_enable =
    ~r.test_two[catr_pkg::BIT_DAC_RTZ_DISABLE];
  assign dac_rtz_lengthen =
    r.test_two[catr_pkg::BIT_DAC_RTZ_LENGTHEN];
  assign dac_amp_class_ab_enable =
    ~r.test_two[catr_pkg::BIT_DAC_AMP_CLASS_A];
  assign dac_double_current =
    r.test_two[catr_pkg::BIT_DAC_DOUBLE_CURRENT];

  // adc dither and bias
  assign adc_dither_enable =
    ~r.test_two[catr_pkg::BIT_ADC_DITHER_DISABLE];
  assign adc_low_bias =
    r.test_two[catr_pkg::BIT_ADC_LOW_BIAS];

  // line output supply and ground tie
  assign line_amp_supply_select =
    r.test_two[catr_pkg::BIT_LINE_AMP_SUPPLY];
  assign line_ground_tie =
    r.test_two[catr_pkg::BIT_LINE_GROUND_TIE];
  // spare bit goes to the analog side as a plain level
  assign analog_spare = r.test_two[catr_pkg::BIT_SPARE];

  // headphone short detector thresholds and modes
  assign short_level_right =
    r.short_ctrl[catr_pkg::SHORT_RIGHT_LEVEL_LSB +: 3];
  assign short_level_left =
    r.short_ctrl[catr_pkg::SHORT_LEFT_LEVEL_LSB +: 3];
  assign short_level_center =
    r.short_ctrl[catr_pkg::SHORT_CENTER_LEVEL_LSB +: 3];
  assign short_mode_side =
    r.short_ctrl[catr_pkg::SHORT_SIDE_MODE_LSB +: 2];
  assign short_mode_common =
    r.short_ctrl[catr_pkg::SHORT_COMMON_MODE_LSB +: 2];

endmodule

`default_nettype wire

/* testbench/catr_regs_chk.sv */
/*
  Checker for the codec analog test register bank.
  Assumes it is bound to catr_regs and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// checker
// ****************************************************************
module catr_regs_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  // dac path
  input wire logic dac_sample_valid,
  input wire logic [15:0] dac_left_in,
  input wire logic [15:0] dac_right_in,
  input wire logic dac_out_valid,
  input wire logic [15:0] dac_left_out,
  input wire logic [15:0] dac_right_out,
  // controls
  input wire logic oscillator_retune_pulse,
  input wire logic dac_sample_edge_flip,
  input wire logic adc_sample_edge_flip,
  input wire logic dac_rtz_enable,
  input wire logic dac_amp_class_ab_enable,
  input wire logic adc_dither_enable,
  input wire logic line_amp_supply_select
);
  // full write to the test register, and a write clearing the trigger
  logic wr_two;
  logic clr_two;
  assign wr_two = psel & penable & pwrite & (pstrb[1:0] == 2'h3)
    & (paddr == catr_pkg::ADDR_TEST_TWO);
  assign clr_two = psel & penable & pwrite & pstrb[1]
    & (paddr == catr_pkg::ADDR_TEST_TWO) & ~pwdata[11];

  // mono bit as last written, to tell a copy from a pass-through
  logic mono_sh;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mono_sh <= 1'b0;
    end else if (psel && penable && pwrite && pstrb[1] &&
        paddr == catr_pkg::ADDR_TEST_TWO) begin
      mono_sh <= pwdata[12];
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  mono_copy_a: assert property (dac_out_valid |->
    dac_left_out == $past(dac_left_in) &&
    dac_right_out == ($past(mono_sh) ? $past(dac_left_in) :
    $past(dac_right_in)))
    else $error("dac output does not follow its inputs");
  retune_single_a: assert property (oscillator_retune_pulse |=>
    !oscillator_retune_pulse) else $error("retune pulse too long");
  retune_cause_a: assert property (oscillator_retune_pulse |->
    $past(clr_two, 2)) else $error("retune pulse without clear");
  dac_sample_a: assert property (wr_two |=>
    dac_sample_edge_flip == $past(pwdata[9]))
    else $error("dac sample edge wrong");
  adc_sample_a: assert property (wr_two |=>
    adc_sample_edge_flip == $past(pwdata[3]))
    else $error("adc sample edge wrong");
  dither_ctrl_a: assert property (wr_two |=>
    adc_dither_enable != $past(pwdata[0])) else $error("dither wrong");
  rtz_ctrl_a: assert property (wr_two |=>
    dac_rtz_enable != $past(pwdata[5])) else $error("rtz enable wrong");
  supply_sel_a: assert property (wr_two |=>
    line_amp_supply_select == $past(pwdata[14]))
    else $error("supply select wrong");
  class_ab_a: assert property (wr_two |=>
    dac_amp_class_ab_enable != $past(pwdata[4]))
    else $error("class ab wrong");
  reserved_zero_a: assert property (psel && penable && !pwrite |->
    prdata[31:16] == 16'h0000 &&
    (paddr != catr_pkg::ADDR_TEST_TWO || !prdata[15]))
    else $error("reserved read bits not zero");
endmodule

bind catr_regs catr_regs_chk catr_regs_chk_i (.sys_clk, .sys_rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .dac_sample_valid,
  .dac_left_in, .dac_right_in, .dac_out_valid, .dac_left_out,
  .dac_right_out, .oscillator_retune_pulse, .dac_sample_edge_flip,
  .adc_sample_edge_flip, .dac_rtz_enable, .dac_amp_class_ab_enable,
  .adc_dither_enable, .line_amp_supply_select);

`default_nettype wire

/* testbench/tb.sv */
/*
  Self-checking bench for the codec analog test register bank.
  Assumes the checker is bound in separately and APB with no wait states.
*/
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// bench top
// ****************************************************************
module tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr, dvalid, dout_valid, retune;
  logic [15:0] dleft = 16'h0000;
  logic [15:0] dright = 16'h0000;
  logic [15:0] dleft_out, dright_out;
  logic sf_d, hf_d, sf_a, hf_a, rtz_en, rtz_len, cab_en, dbl;
  logic dith_en, low_b, sup, gnd, spare;
  logic [2:0] lv_r, lv_l, lv_c;
  logic [1:0] md_s, md_c;
  logic [31:0] rdv;
  logic err;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int pulses = 0;
  wire logic [15:0] obs = {1'b0, sup, spare, 2'h0, gnd, sf_d, hf_d,
    rtz_len, dbl, ~rtz_en, ~cab_en, sf_a, hf_a, low_b, ~dith_en};
  wire logic [15:0] sobs = {1'b0, lv_r, 1'b0, lv_l, 1'b0, lv_c, md_s, md_c};

  initial dvalid = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  catr_regs catr_regs_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dac_sample_valid(dvalid), .dac_left_in(dleft),
    .dac_right_in(dright), .dac_out_valid(dout_valid),
    .dac_left_out(dleft_out), .dac_right_out(dright_out),
    .oscillator_retune_pulse(retune), .dac_sample_edge_flip(sf_d),
    .dac_handoff_edge_flip(hf_d), .adc_sample_edge_flip(sf_a),
    .adc_handoff_edge_flip(hf_a), .dac_rtz_enable(rtz_en),
    .dac_rtz_lengthen(rtz_len), .dac_amp_class_ab_enable(cab_en),
    .dac_double_current(dbl), .adc_dither_enable(dith_en),
    .adc_low_bias(low_b), .line_amp_supply_select(sup),
    .line_ground_tie(gnd), .analog_spare(spare),
    .short_level_right(lv_r), .short_level_left(lv_l),
    .short_level_center(lv_c), .short_mode_side(md_s),
    .short_mode_common(md_c));

  // pulse counter and watchdog
  always @(posedge sys_clk) begin
    if (retune === 1'b1) pulses++;
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [9:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic t_reset;
    apb(1'b0, catr_pkg::ADDR_TEST_TWO, 32'h0);
    chk(rdv, 32'h0);
    chk(obs, 16'h0000);
  endtask

  task automatic t_fields;
    logic [15:0] v;
    for (int i = 0; i < 16; i++) begin
      v = 16'h0001 << i;
      apb(1'b1, catr_pkg::ADDR_TEST_TWO, {16'h0, v});
      chk(obs, v & 16'h67FF);
      apb(1'b0, catr_pkg::ADDR_TEST_TWO, 32'h0);
      chk(rdv, {16'h0, v & 16'h7FFF});
    end
  endtask

  task automatic t_mono;
    apb(1'b1, catr_pkg::ADDR_TEST_TWO, 32'h00001000);
    for (int m = 0; m < 2; m++) begin
      dvalid <= 1'b1;
      dleft <= 16'h1A2B;
      dright <= 16'hC3D4;
      @(posedge sys_clk);
      dvalid <= 1'b0;
      @(posedge sys_clk);
      chk(dout_valid, 1'b1);
      chk(dleft_out, 16'h1A2B);
      chk(dright_out, (m == 0) ? 16'h1A2B : 16'hC3D4);
      apb(1'b1, catr_pkg::ADDR_TEST_TWO, 32'h0);
    end
  endtask

  task automatic t_retune;
    int p0;
    logic [7:0] c0;
    p0 = pulses;
    apb(1'b0, catr_pkg::ADDR_TEST_STATUS, 32'h0);
    c0 = rdv[7:0];
    apb(1'b1, catr_pkg::ADDR_TEST_TWO, 32'h00000800);
    apb(1'b1, catr_pkg::ADDR_TEST_TWO, 32'h00000800);
    repeat (4) @(posedge sys_clk);
    chk(32'(pulses - p0), 32'h0);
    apb(1'b1, catr_pkg::ADDR_TEST_TWO, 32'h0);
    repeat (4) @(posedge sys_clk);
    chk(32'(pulses - p0), 32'h1);
    apb(1'b0, catr_pkg::ADDR_TEST_STATUS, 32'h0);
    chk(rdv[7:0], c0 + 8'h01);
  endtask

  task automatic t_misc;
    apb(1'b1, catr_pkg::ADDR_SHORT_CTRL, 32'hFFFFFFFF);
    apb(1'b0, catr_pkg::ADDR_SHORT_CTRL, 32'h0);
    chk(rdv, 32'h0000777F);
    chk(sobs, 16'h777F);
    apb(1'b0, 10'h3FC, 32'h0);
    chk(err, 1'b1);
    chk(rdv, 32'h0);
    apb(1'b1, 10'h3FC, 32'hFFFFFFFF);
    chk(err, 1'b1);
    apb(1'b0, catr_pkg::ADDR_TEST_TWO, 32'h0);
    chk(rdv, 32'h0);
    pstrb <= 4'h2;
    apb(1'b1, catr_pkg::ADDR_SHORT_CTRL, 32'h0);
    pstrb <= 4'hF;
    apb(1'b0, catr_pkg::ADDR_SHORT_CTRL, 32'h0);
    chk(rdv, 32'h0000007F);
    chk(sobs, 16'h007F);
  endtask

  // reset in mid-run clears every field and the armed watcher
  task automatic t_rerun;
    int p0;
    p0 = pulses;
    apb(1'b1, catr_pkg::ADDR_TEST_TWO, 32'h00007FFF);
    apb(1'b1, catr_pkg::ADDR_SHORT_CTRL, 32'h0000777F);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    chk(obs, 16'h0000);
    chk(sobs, 16'h0000);
    apb(1'b0, catr_pkg::ADDR_TEST_TWO, 32'h0);
    chk(rdv, 32'h0);
    chk(32'(pulses - p0), 32'h0);
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_fields();
    t_mono();
    t_retune();
    t_misc();
    t_rerun();
    complete_run();
  end
endmodule

`default_nettype wire
